// file: rtl/ulc_top.sv
// Session controller that records instrument data to a removable USB stick
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

// Operation
// - Sessions start only when enabled and interval and start/stop mode are set.
// - Output-linked mode starts a session on every DC output turn-on.
// - Manual mode starts and stops only on register commands, ignoring the output.
// - Active flag while a session runs; error flag on stick full or removal.
// - A stop command, or in output-linked mode a DC output turn-off, ends the session and closes its file.
// - Each start opens a new file numbered from 1, skipping numbers already used.
// - No single log file grows beyond 4 GB.
// - No more than 1024 log files are kept in the folder.
// - Output-linked mode also ends logging when an alarm forces the output off.
// - Manual mode keeps recording through alarms.
// - Records hold elapsed session time plus set and actual U, I and P.
// - Records hold regulation mode, alarm status, resistance flag and output state.
// - Resistance values are genuine only in resistance mode, else not-applicable.
// - A setting selects European or US column separators.
// - Units are appended by default; a setting suppresses them.
module ulc_top #(
  parameter int CYC_PER_MS = ulc_pkg::CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dc_output_on,
  input wire ulc_pkg::ulc_reg_mode_e reg_mode,
  input wire logic resistance_regulation_mode,
  input wire logic [ulc_pkg::ALM_W-1:0] alarm_status,
  input wire ulc_pkg::ulc_meas_s meas,
  input wire logic stick_present_pin,
  input wire logic stick_full_pin,
  output logic probe_req,
  output logic [ulc_pkg::FNUM_W-1:0] probe_num,
  input wire logic probe_done,
  input wire logic probe_exists,
  output logic file_open,
  output logic file_close,
  output logic [ulc_pkg::FNUM_W-1:0] file_num,
  output logic rec_valid,
  input wire logic rec_ready,
  output ulc_pkg::ulc_rec_s rec_data,
  input wire logic [15:0] rec_len,
  output logic logging_active,
  output logic logging_error
);
  import ulc_pkg::*;

  // ****
  // State
  // ****
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PROBE = 2'b01,
    S_WAIT = 2'b10,
    S_RUN = 2'b11
  } ulc_state_e;

  typedef struct packed {
    ulc_state_e state;
    logic [2:0] pres_s;
    logic [2:0] full_s;
    logic present;
    logic full;
    logic dc_d;
    logic [FNUM_W-1:0] cand;
    logic [FNUM_W-1:0] file;
    logic probe_req;
    logic file_open;
    logic file_close;
    logic active;
    logic err_full;
    logic err_removed;
    logic err_size;
    logic err_count;
    logic rec_valid;
    ulc_rec_s rec;
    logic [32:0] size;
    logic [31:0] rec_count;
  } ulc_core_s;
  ulc_core_s q, next_q;

  ulc_cfg_if cfg();

  logic [31:0] elapsed_ms;
  logic tick;
  logic cfg_ok;
  logic dc_rise;
  logic dc_fall;
  logic start_req;
  logic stop_req;
  logic halted;
  logic over_size;
  logic [32:0] size_after;

  // ****
  // Submodules
  // ****
  ulc_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cfg(cfg.regs)
  );

  ulc_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(q.active),
    .interval_ms(cfg.interval_ms),
    .elapsed_ms(elapsed_ms),
    .tick(tick)
  );

  // ****
  // Outputs and status
  // ****
  assign probe_req = q.probe_req;
  assign probe_num = q.cand;
  assign file_open = q.file_open;
  assign file_close = q.file_close;
  assign file_num = q.file;
  assign rec_data = q.rec;
  assign logging_active = q.active;
  assign logging_error = q.err_full || q.err_removed || q.err_size || q.err_count;
  assign halted = logging_error;

  assign size_after = q.size + {17'h0, rec_len};
  assign over_size = size_after > MAX_FILE_BYTES;
  assign rec_valid = q.rec_valid && !over_size && !halted;

  assign cfg.status = {25'h0, q.present, q.err_count, q.err_size, q.err_removed, q.err_full,
                       logging_error, q.active};
  assign cfg.elapsed_ms = elapsed_ms;
  assign cfg.rec_count = q.rec_count;
  assign cfg.file_num = q.file;

  // ****
  // Start and stop decisions
  // ****
  assign dc_rise = dc_output_on && !q.dc_d;
  assign dc_fall = !dc_output_on && q.dc_d;
  assign cfg_ok = cfg.enable && cfg.mode_set && (cfg.interval_ms != 32'h0);
  // output-linked start; manual start from command only
  assign start_req = cfg_ok && (cfg.manual ? cfg.start_cmd : dc_rise);
  // stop on command or output off; alarm trips show up as output off
  // manual mode looks only at the command, so alarms do not end it
  assign stop_req = cfg.stop_cmd || (!cfg.manual && dc_fall);

  always_comb begin
    next_q = q;
    next_q.probe_req = 1'b0;
    next_q.file_open = 1'b0;
    next_q.file_close = 1'b0;
    next_q.dc_d = dc_output_on;

    // Pin levels count once two stages agree
    next_q.pres_s = {q.pres_s[1:0], stick_present_pin};
    next_q.full_s = {q.full_s[1:0], stick_full_pin};
    if (q.pres_s[1] == q.pres_s[2]) begin
      next_q.present = q.pres_s[2];
    end
    if (q.full_s[1] == q.full_s[2]) begin
      next_q.full = q.full_s[2];
    end

    unique case (q.state)
      S_IDLE: begin
        if (start_req && q.present) begin
          // numbering restarts at one for every session
          next_q.cand = FIRST_FILE;
          next_q.err_full = 1'b0;
          next_q.err_removed = 1'b0;
          next_q.err_size = 1'b0;
          next_q.err_count = 1'b0;
          next_q.state = S_PROBE;
        end
      end
      S_PROBE: begin
        next_q.probe_req = 1'b1;
        next_q.state = S_WAIT;
      end
      S_WAIT: begin
        if (stop_req || !q.present) begin
          next_q.err_removed = !q.present;
          next_q.state = S_IDLE;
        end else if (probe_done) begin
          if (!probe_exists) begin
            next_q.file = q.cand;
            next_q.file_open = 1'b1;
            next_q.active = 1'b1;
            next_q.size = '0;
            next_q.rec_count = '0;
            next_q.rec_valid = 1'b0;
            next_q.state = S_RUN;
          end else if (q.cand == MAX_FILES) begin
            next_q.err_count = 1'b1;
            next_q.state = S_IDLE;
          end else begin
            next_q.cand = q.cand + FNUM_W'(1);
            next_q.state = S_PROBE;
          end
        end
      end
      S_RUN: begin
        if (!q.present) begin
          next_q.err_removed = 1'b1;
        end
        if (q.full) begin
          next_q.err_full = 1'b1;
        end
        if (q.rec_valid && over_size) begin
          next_q.err_size = 1'b1;
        end
        if (rec_valid && rec_ready) begin
          next_q.rec_valid = 1'b0;
          next_q.size = size_after;
          next_q.rec_count = q.rec_count + 32'h1;
        end
        // pending record dropped once an error stands
        if (halted) begin
          next_q.rec_valid = 1'b0;
        end
        // one record captured per interval strobe
        if (tick && !halted && !q.rec_valid) begin
          next_q.rec_valid = 1'b1;
          next_q.rec.meas = meas;
          next_q.rec.elapsed_ms = elapsed_ms;
          next_q.rec.r_na = !resistance_regulation_mode;
          next_q.rec.meas.r_set = resistance_regulation_mode ? meas.r_set : '0;
          next_q.rec.meas.r_act = resistance_regulation_mode ? meas.r_act : '0;
          next_q.rec.r_mode_on = resistance_regulation_mode;
          next_q.rec.output_on = dc_output_on;
          next_q.rec.reg_mode = reg_mode;
          next_q.rec.alarms = alarm_status;
          next_q.rec.sep_us = cfg.sep_us;
          next_q.rec.no_units = cfg.no_units;
        end
        // end the session and close its file
        if (stop_req) begin
          next_q.rec_valid = 1'b0;
          next_q.active = 1'b0;
          next_q.file_close = 1'b1;
          next_q.state = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.state <= S_IDLE;
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule

// file: shared/ulc_pkg.sv
// Constants and types shared by the USB log session controller
package ulc_pkg;
  // ****
  // Timing
  // ****
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  // ****
  // Widths and limits
  // ****
  localparam int VAL_W = 16;
  localparam int ALM_W = 8;
  localparam int FNUM_W = 11;
  localparam logic [FNUM_W-1:0] FIRST_FILE = 11'h001;
  localparam logic [FNUM_W-1:0] MAX_FILES = 11'h400;
  localparam logic [32:0] MAX_FILE_BYTES = 33'h100000000;

  // ****
  // Register map
  // ****
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_INTERVAL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_ELAPSED = 8'h10;
  localparam logic [7:0] OFF_RECORDS = 8'h14;
  localparam logic [7:0] OFF_FILE = 8'h18;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_MODE_SET = 2;
  localparam int CTRL_SEP_US = 3;
  localparam int CTRL_NO_UNITS = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000001f;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] INTERVAL_RST = 32'h00000000;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REG_CV = 2'b00,
    REG_CC = 2'b01,
    REG_CP = 2'b10,
    REG_CR = 2'b11
  } ulc_reg_mode_e;

  typedef struct packed {
    logic [VAL_W-1:0] u_set;
    logic [VAL_W-1:0] u_act;
    logic [VAL_W-1:0] i_set;
    logic [VAL_W-1:0] i_act;
    logic [VAL_W-1:0] p_set;
    logic [VAL_W-1:0] p_act;
    logic [VAL_W-1:0] r_set;
    logic [VAL_W-1:0] r_act;
  } ulc_meas_s;

  typedef struct packed {
    ulc_meas_s meas;
    logic r_na;
    logic r_mode_on;
    logic output_on;
    ulc_reg_mode_e reg_mode;
    logic [ALM_W-1:0] alarms;
    logic [31:0] elapsed_ms;
    logic sep_us;
    logic no_units;
  } ulc_rec_s;
endpackage

// file: shared/ulc_cfg_if.sv
// Settings and status carried between the register slave and the session core
`timescale 1ns/100ps
interface ulc_cfg_if;
  import ulc_pkg::*;
  logic enable;
  logic manual;
  logic mode_set;
  logic sep_us;
  logic no_units;
  logic [31:0] interval_ms;
  logic start_cmd;
  logic stop_cmd;
  logic [31:0] status;
  logic [31:0] elapsed_ms;
  logic [31:0] rec_count;
  logic [FNUM_W-1:0] file_num;
  modport regs(output enable, manual, mode_set, sep_us, no_units, interval_ms, start_cmd, stop_cmd,
               input status, elapsed_ms, rec_count, file_num);
  modport core(input enable, manual, mode_set, sep_us, no_units, interval_ms, start_cmd, stop_cmd,
               output status, elapsed_ms, rec_count, file_num);
endinterface

// file: rtl/ulc_tick.sv
// Millisecond session clock and record interval strobe
`timescale 1ns/100ps
module ulc_tick #(
  parameter int CYC_PER_MS = ulc_pkg::CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [31:0] interval_ms,
  output logic [31:0] elapsed_ms,
  output logic tick
);
  import ulc_pkg::*;
  localparam int CW = $clog2(CYC_PER_MS + 1);
  localparam logic [CW-1:0] PRE_LAST = CW'(CYC_PER_MS - 1);

  typedef struct packed {
    logic [CW-1:0] pre;
    logic [31:0] ms;
    logic [31:0] iv;
    logic tick;
  } ulc_tick_s;
  ulc_tick_s q, next_q;

  assign elapsed_ms = q.ms;
  assign tick = q.tick;

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (!run) begin
      // Held at zero so every session is timed from its own start
      next_q.pre = '0;
      next_q.ms = '0;
      next_q.iv = '0;
    end else if (q.pre == PRE_LAST) begin
      next_q.pre = '0;
      next_q.ms = q.ms + 32'h1;
      if (q.iv + 32'h1 >= interval_ms) begin
        next_q.iv = '0;
        next_q.tick = 1'b1;
      end else begin
        next_q.iv = q.iv + 32'h1;
      end
    end else begin
      next_q.pre = q.pre + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule

// file: rtl/ulc_axil_regs.sv
// AXI4-Lite register slave of the USB log session controller
`timescale 1ns/100ps
module ulc_axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ulc_cfg_if.regs cfg
);
  import ulc_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] interval;
    logic start;
    logic stop;
  } ulc_axs_s;
  ulc_axs_s q, next_q;
  logic [31:0] rd;
  logic rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Readies drop while a response is owed
  assign s_axi_awready = ce && !q.aw_got && !q.bvalid;
  assign s_axi_wready = ce && !q.w_got && !q.bvalid;
  assign s_axi_arready = ce && !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign cfg.enable = q.ctrl[CTRL_EN];
  assign cfg.manual = q.ctrl[CTRL_MANUAL];
  assign cfg.mode_set = q.ctrl[CTRL_MODE_SET];
  assign cfg.sep_us = q.ctrl[CTRL_SEP_US];
  assign cfg.no_units = q.ctrl[CTRL_NO_UNITS];
  assign cfg.interval_ms = q.interval;
  assign cfg.start_cmd = q.start;
  assign cfg.stop_cmd = q.stop;

  always_comb begin
    rd = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd = q.ctrl;
      OFF_CMD: rd = '0;
      OFF_INTERVAL: rd = q.interval;
      OFF_STATUS: rd = cfg.status;
      OFF_ELAPSED: rd = cfg.elapsed_ms;
      OFF_RECORDS: rd = cfg.rec_count;
      OFF_FILE: rd = {{(32-FNUM_W){1'b0}}, cfg.file_num};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.start = 1'b0;
    next_q.stop = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      case (q.awaddr)
        OFF_CTRL: next_q.ctrl = merge(q.ctrl, q.wdata, q.wstrb) & CTRL_MASK;
        OFF_INTERVAL: next_q.interval = merge(q.interval, q.wdata, q.wstrb);
        OFF_CMD: begin
          next_q.start = q.wstrb[0] && q.wdata[CMD_START];
          next_q.stop = q.wstrb[0] && q.wdata[CMD_STOP];
        end
        OFF_STATUS, OFF_ELAPSED, OFF_RECORDS, OFF_FILE: next_q.bresp = RESP_OKAY;
        default: next_q.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd;
      next_q.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.interval <= INTERVAL_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule

// file: verification/ulc_asserts.sv
// Assertion checker for the USB log session controller
`timescale 1ns/100ps
module ulc_asserts
  import ulc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic probe_req,
  input wire logic [ulc_pkg::FNUM_W-1:0] probe_num,
  input wire logic probe_done,
  input wire logic probe_exists,
  input wire logic file_open,
  input wire logic file_close,
  input wire logic [ulc_pkg::FNUM_W-1:0] file_num,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire ulc_pkg::ulc_rec_s rec_data,
  input wire logic logging_active,
  input wire logic logging_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****
  // Session, record stream and write response
  // ****
  chk_open_answer: assert property (
    file_open |-> $past(probe_done) && !$past(probe_exists) && logging_active && file_num == $past(probe_num))
    else $error("bad file open");
  chk_probe_range: assert property (
    probe_req |-> probe_num >= FIRST_FILE && probe_num <= MAX_FILES ##1 !probe_req)
    else $error("bad probe");
  chk_open_range: assert property (
    file_open |-> file_num >= FIRST_FILE && file_num <= MAX_FILES)
    else $error("bad file number");
  chk_close_ends: assert property (
    file_close |-> !logging_active && !rec_valid ##1 !file_close)
    else $error("bad close");
  chk_err_quiet: assert property (
    logging_error |-> !rec_valid)
    else $error("record after error");
  chk_rec_live: assert property (
    rec_valid |-> logging_active)
    else $error("stray record");
  chk_rec_hold: assert property (
    rec_valid && !rec_ready |=> !rec_valid || $stable(rec_data))
    else $error("pending record changed");
  chk_r_marker: assert property (
    rec_valid |-> rec_data.r_na == !rec_data.r_mode_on && (!rec_data.r_na || rec_data.meas[31:0] == 32'h0))
    else $error("resistance fields wrong");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

bind ulc_top ulc_asserts ulc_asserts_i (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .probe_req,
  .probe_num, .probe_done, .probe_exists, .file_open, .file_close, .file_num, .rec_valid, .rec_ready, .rec_data,
  .logging_active, .logging_error);

// file: verification/ulc_stick_model.sv
// Behavioural USB stick that answers file probes and sinks records
`timescale 1ns/100ps
module ulc_stick_model
  import ulc_pkg::*;
(
  input wire logic aclk,
  input wire logic slow,
  input wire logic [ulc_pkg::FNUM_W-1:0] used,
  input wire logic probe_req,
  input wire logic [ulc_pkg::FNUM_W-1:0] probe_num,
  output logic probe_done,
  output logic probe_exists,
  input wire logic file_open,
  input wire logic [ulc_pkg::FNUM_W-1:0] file_num,
  input wire logic rec_valid,
  output logic rec_ready,
  input wire ulc_pkg::ulc_rec_s rec_data,
  output logic [15:0] rec_len,
  output logic [31:0] n_rec,
  output ulc_pkg::ulc_rec_s last_rec,
  output logic [31:0] prev_ms
);
  logic [FNUM_W-1:0] hi = '0;
  logic [2:0] wait_c = '0;
  logic [1:0] cyc = '0;
  initial {probe_done, probe_exists, n_rec, last_rec, prev_ms} = '0;
  // Stalls stay under one record interval
  assign rec_ready = !slow || cyc == 2'h3;
  assign rec_len = 16'h0040;
  always @(posedge aclk) begin
    cyc <= cyc + 2'h1;
    probe_done <= 1'b0;
    probe_exists <= ~probe_exists;
    hi <= file_open ? file_num : (used > hi ? used : hi);
    if (probe_req) begin
      wait_c <= slow ? 3'h4 : 3'h1;
    end else if (wait_c != 3'h0) begin
      wait_c <= wait_c - 3'h1;
      if (wait_c == 3'h1) begin
        probe_done <= 1'b1;
        probe_exists <= probe_num <= hi;
      end
    end
    if (rec_valid && rec_ready) begin
      n_rec <= n_rec + 1;
      prev_ms <= last_rec.elapsed_ms;
      last_rec <= rec_data;
    end
  end
endmodule

// file: verification/tb.sv
// Self-checking bench for the USB log session controller
`timescale 1ns/100ps
module tb;
  import ulc_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, slow = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, n_rec, prev_ms;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dc_output_on = 0, resistance_regulation_mode = 0, stick_present_pin = 1, stick_full_pin = 0;
  ulc_reg_mode_e reg_mode = REG_CV;
  logic [ALM_W-1:0] alarm_status = '0;
  ulc_meas_s meas = '0;
  logic probe_req, probe_done, probe_exists, file_open, file_close, rec_valid, rec_ready;
  logic logging_active, logging_error;
  logic [FNUM_W-1:0] probe_num, file_num, used = '0;
  ulc_rec_s rec_data, last_rec;
  logic [15:0] rec_len;
  int n_mismatch = 0, total_checks = 0, n_open = 0, n_probe = 0;

  // Short ms keeps sessions brief
  ulc_top #(.CYC_PER_MS(4)) ulc_top_i (.*);
  ulc_stick_model ulc_stick_model_i (.*);

  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (file_open === 1'b1) n_open <= n_open + 1;
    if (probe_req === 1'b1) n_probe <= n_probe + 1;
  end
  // ****
  // Shared tasks
  // ****
  task chk(input string nm, input logic [127:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task results();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task tmo(input string nm);
    chk(nm, 1, 0);
    results();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (60) begin
      @(negedge aclk);
      if (s_axi_bvalid === 1'b1) begin
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        return;
      end
      ta = s_axi_awvalid && s_axi_awready === 1'b1;
      tw = s_axi_wvalid && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    tmo("bvalid");
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    bit ta;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (60) begin
      @(negedge aclk);
      if (s_axi_rvalid === 1'b1) begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        return;
      end
      ta = s_axi_arvalid && s_axi_arready === 1'b1;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    tmo("rvalid");
  endtask
  // Kind 0 open, 1 close, 2 error
  task await(input int k, input int lim);
    repeat (lim) begin
      @(negedge aclk);
      if ((k == 0 ? file_open : k == 1 ? file_close : logging_error) === 1'b1) return;
    end
    tmo("event");
  endtask
  task recs(input int k);
    int goal;
    goal = n_rec + k;
    repeat (40 * k) begin
      @(negedge aclk);
      if (n_rec >= goal) return;
    end
    tmo("records");
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs();
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_INTERVAL, INTERVAL_RST);
    wr(OFF_CTRL, 32'hffffffff);
    rd(OFF_CTRL, CTRL_MASK);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, '0, RESP_SLVERR);
    wr(OFF_STATUS, 32'h3);
    rd(OFF_STATUS, 32'h40);
  endtask
  task t_cfg(input logic [31:0] c, iv);
    int p;
    wr(OFF_CTRL, c);
    wr(OFF_INTERVAL, iv);
    p = n_probe;
    dc_output_on <= 1'b1;
    repeat (20) @(posedge aclk);
    dc_output_on <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("no start", p, n_probe);
  endtask
  task t_linked();
    used <= 11'h2;
    reg_mode <= REG_CR;
    resistance_regulation_mode <= 1'b1;
    meas <= 128'h11112222333344445555666677778888;
    wr(OFF_CTRL, 32'hd);
    wr(OFF_INTERVAL, 32'h2);
    for (int s = 0; s < 2; s++) begin
      @(posedge aclk);
      slow <= s[0];
      alarm_status <= '0;
      dc_output_on <= 1'b1;
      await(0, 400);
      chk("file", 3 + s, file_num);
      chk("active", 1, logging_active);
      recs(3);
      chk("period", 2, last_rec.elapsed_ms - prev_ms);
      chk("meas", meas, last_rec.meas);
      chk("flags", {3'b011, REG_CR, 8'h0}, {last_rec.r_na, last_rec.r_mode_on, last_rec.output_on,
        last_rec.reg_mode, last_rec.alarms});
      chk("format", 2'h2, {last_rec.sep_us, last_rec.no_units});
      @(posedge aclk);
      alarm_status <= 8'h4;
      dc_output_on <= 1'b0;
      await(1, 4);
      chk("stop", 0, logging_active);
    end
  endtask
  task t_manual();
    int c;
    @(posedge aclk);
    reg_mode <= REG_CC;
    resistance_regulation_mode <= 1'b0;
    wr(OFF_CTRL, 32'h17);
    c = n_probe;
    dc_output_on <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("dc start", c, n_probe);
    wr(OFF_CMD, 32'h1);
    await(0, 400);
    @(posedge aclk);
    dc_output_on <= 1'b0;
    alarm_status <= 8'h10;
    recs(2);
    chk("run", 1, logging_active);
    chk("meas", {meas[127:32], 32'h0}, last_rec.meas);
    chk("flags", {3'b100, REG_CC, 8'h10, 2'h1}, {last_rec.r_na, last_rec.r_mode_on, last_rec.output_on,
      last_rec.reg_mode, last_rec.alarms, last_rec.sep_us, last_rec.no_units});
    wr(OFF_CMD, 32'h2);
    await(1, 20);
  endtask
  task t_error();
    int c;
    wr(OFF_CMD, 32'h1);
    await(0, 400);
    @(posedge aclk);
    stick_full_pin <= 1'b1;
    await(2, 20);
    c = n_rec;
    repeat (30) @(posedge aclk);
    chk("writes", c, n_rec);
    rd(OFF_STATUS, 32'h47);
    stick_full_pin <= 1'b0;
    wr(OFF_CMD, 32'h2);
    wr(OFF_CMD, 32'h1);
    await(0, 400);
    chk("cleared", 0, logging_error);
    recs(1);
    @(posedge aclk);
    stick_present_pin <= 1'b0;
    await(2, 20);
    @(posedge aclk);
    stick_present_pin <= 1'b1;
    wr(OFF_CMD, 32'h2);
    repeat (8) @(posedge aclk);
  endtask
  task t_files();
    int p, o;
    used <= MAX_FILES;
    p = n_probe;
    o = n_open;
    wr(OFF_CMD, 32'h1);
    for (int n = 0; n < 9000 && n_probe - p < 1024; n++) @(posedge aclk);
    repeat (6) @(posedge aclk);
    chk("probes", 1024, n_probe - p);
    chk("opens", o, n_open);
    chk("error", 1, logging_error);
    rd(OFF_STATUS, 32'h62);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cfg(32'h1, 32'h2);
    t_cfg(32'h5, '0);
    t_cfg(32'h4, 32'h2);
    t_linked();
    t_manual();
    t_error();
    t_files();
    results();
  end
endmodule
